/* File: risc_pkg.sv */
// risc_pkg: constants for the reference input select control block
`default_nettype none
package risc_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] RISC_CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] RISC_STATUS_OFFSET = 12'h004;
  localparam logic [11:0] RISC_PLLST_OFFSET  = 12'h008;
  // ==========================================================================
  // control register field positions
  localparam int RISC_AUTO_BIT      = 5;
  localparam int RISC_HOLD_BIT      = 4;
  localparam int RISC_SEC_PWR_BIT   = 3;
  localparam int RISC_PRI_PWR_BIT   = 2;
  localparam int RISC_DIFF_BIT      = 1;
  localparam int RISC_RDBK_DIS_BIT  = 0;
  localparam int RISC_CTRL_WIDTH    = 6;
  localparam logic [5:0] RISC_CTRL_RESET = 6'h00;
  // ==========================================================================
  // status register field positions
  localparam int RISC_ST_SEL_BIT      = 0;
  localparam int RISC_ST_PRI_PWR_BIT  = 1;
  localparam int RISC_ST_SEC_PWR_BIT  = 2;
  localparam int RISC_ST_PRI_GOOD_BIT = 3;
  localparam int RISC_ST_SEC_GOOD_BIT = 4;
  localparam int RISC_ST_DIFF_BIT     = 5;
  // ==========================================================================
  // selected reference
  typedef enum logic [0:0] {
    RISC_SEL_PRIMARY   = 1'b0,
    RISC_SEL_SECONDARY = 1'b1
  } risc_sel_t;
  localparam logic [7:0]  RISC_PLLST_RESET = 8'h00;
  localparam logic [31:0] RISC_ZERO_WORD   = 32'h0000_0000;
endpackage : risc_pkg
`default_nettype wire

/* File: risc_ref_select.sv */
// risc_ref_select: reference input selection, power and readback gating
`timescale 1ns/1ps
`default_nettype none
module risc_ref_select (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        primary_status_good,
  input  wire logic        secondary_status_good,
  input  wire logic        manual_select_secondary,
  input  wire logic [7:0]  pll_status,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             primary_input_power,
  output logic             secondary_input_power,
  output logic             differential_mode,
  output logic             select_secondary
);
  // ==========================================================================
  // state
  logic [5:0]            ctrl_reg, ctrl_next;
  risc_pkg::risc_sel_t   sel_reg, sel_next;
  logic                  pri_pwr_reg, pri_pwr_next;
  logic                  sec_pwr_reg, sec_pwr_next;
  logic                  diff_reg, diff_next;
  logic [31:0]           prdata_reg, prdata_next;
  logic                  pready_reg, pready_next;
  logic                  pslverr_reg, pslverr_next;

  // ==========================================================================
  // control fields and bus decode
  logic                  auto_en;
  logic                  hold_sec;
  logic                  rdbk_dis;
  logic                  access;
  logic                  hit_ctrl;
  logic                  hit_status;
  logic                  hit_pllst;
  logic                  hit_none;
  logic [31:0]           ctrl_word;
  logic [31:0]           status_word;
  logic [31:0]           pllst_word;
  logic [31:0]           rd_word;

  assign auto_en  = ctrl_reg[risc_pkg::RISC_AUTO_BIT];
  assign hold_sec = ctrl_reg[risc_pkg::RISC_HOLD_BIT];
  assign rdbk_dis = ctrl_reg[risc_pkg::RISC_RDBK_DIS_BIT];
  // one wait state: pready rises in the cycle after the first access edge
  assign access   = psel && penable && !pready_reg;

  // ==========================================================================
  // address decode
  always_comb begin
    hit_ctrl   = 1'b0;
    hit_status = 1'b0;
    hit_pllst  = 1'b0;
    hit_none   = 1'b0;
    if (paddr == risc_pkg::RISC_CTRL_OFFSET) begin
      hit_ctrl = 1'b1;
    end else if (paddr == risc_pkg::RISC_STATUS_OFFSET) begin
      hit_status = 1'b1;
    end else if (paddr == risc_pkg::RISC_PLLST_OFFSET) begin
      hit_pllst = 1'b1;
    end else begin
      // unmapped address answers with an error
      hit_none = 1'b1;
    end
  end

  // ==========================================================================
  // readback words
  always_comb begin
    ctrl_word   = risc_pkg::RISC_ZERO_WORD;
    status_word = risc_pkg::RISC_ZERO_WORD;
    pllst_word  = risc_pkg::RISC_ZERO_WORD;
    // upper control bits are not stored and read as zero
    ctrl_word[risc_pkg::RISC_CTRL_WIDTH-1:0]   = ctrl_reg;
    status_word[risc_pkg::RISC_ST_SEL_BIT]      = sel_reg;
    status_word[risc_pkg::RISC_ST_PRI_PWR_BIT]  = pri_pwr_reg;
    status_word[risc_pkg::RISC_ST_SEC_PWR_BIT]  = sec_pwr_reg;
    status_word[risc_pkg::RISC_ST_PRI_GOOD_BIT] = primary_status_good;
    status_word[risc_pkg::RISC_ST_SEC_GOOD_BIT] = secondary_status_good;
    status_word[risc_pkg::RISC_ST_DIFF_BIT]     = diff_reg;
    if (!rdbk_dis) begin
      pllst_word[7:0] = pll_status;
    end
  end

  // ==========================================================================
  // read data select
  always_comb begin
    rd_word = risc_pkg::RISC_ZERO_WORD;
    if (hit_ctrl) begin
      rd_word = ctrl_word;
    end else if (hit_status) begin
      rd_word = status_word;
    end else if (hit_pllst) begin
      rd_word = pllst_word;
    end
  end

  // ==========================================================================
  // apb slave
  always_comb begin
    prdata_next  = prdata_reg;
    pready_next  = 1'b0;
    pslverr_next = 1'b0;
    if (access) begin
      pready_next  = 1'b1;
      pslverr_next = hit_none;
      // writes answer with zero data so no stale word looks valid
      prdata_next  = pwrite ? risc_pkg::RISC_ZERO_WORD : rd_word;
    end
  end

  // ==========================================================================
  // control register
  always_comb begin
    ctrl_next = ctrl_reg;
    // status and pll words are read only; writes to them are dropped
    if (access && pwrite && hit_ctrl) begin
      ctrl_next = pwdata[risc_pkg::RISC_CTRL_WIDTH-1:0];
    end
  end

  // ==========================================================================
  // reference selection and power
  always_comb begin
    sel_next     = sel_reg;
    pri_pwr_next = ctrl_reg[risc_pkg::RISC_PRI_PWR_BIT];
    sec_pwr_next = ctrl_reg[risc_pkg::RISC_SEC_PWR_BIT];
    diff_next    = ctrl_reg[risc_pkg::RISC_DIFF_BIT];
    if (auto_en) begin
      // hardware owns power; both inputs stay up to watch them
      pri_pwr_next = 1'b1;
      sec_pwr_next = 1'b1;
      case (sel_reg)
        risc_pkg::RISC_SEL_PRIMARY: begin
          if (!primary_status_good && secondary_status_good) begin
            sel_next = risc_pkg::RISC_SEL_SECONDARY;
          end
        end
        risc_pkg::RISC_SEL_SECONDARY: begin
          if (!hold_sec && primary_status_good) begin
            sel_next = risc_pkg::RISC_SEL_PRIMARY;
          end
        end
        default: sel_next = risc_pkg::RISC_SEL_PRIMARY;
      endcase
    end else begin
      // manual switchover follows the select input
      sel_next = manual_select_secondary ? risc_pkg::RISC_SEL_SECONDARY
                                         : risc_pkg::RISC_SEL_PRIMARY;
    end
    // differential mode has no separate inputs to switch between, so the primary is forced
    // single input in differential mode
    if (diff_next) begin
      sel_next = risc_pkg::RISC_SEL_PRIMARY;
    end
  end

  // ==========================================================================
  // bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= risc_pkg::RISC_ZERO_WORD;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // ==========================================================================
  // control register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= risc_pkg::RISC_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ==========================================================================
  // reference registers
  // power and mode leave reset at the control defaults, so no input powers early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg     <= risc_pkg::RISC_SEL_PRIMARY;
      pri_pwr_reg <= risc_pkg::RISC_CTRL_RESET[risc_pkg::RISC_PRI_PWR_BIT];
      sec_pwr_reg <= risc_pkg::RISC_CTRL_RESET[risc_pkg::RISC_SEC_PWR_BIT];
      diff_reg    <= risc_pkg::RISC_CTRL_RESET[risc_pkg::RISC_DIFF_BIT];
    end else begin
      sel_reg     <= sel_next;
      pri_pwr_reg <= pri_pwr_next;
      sec_pwr_reg <= sec_pwr_next;
      diff_reg    <= diff_next;
    end
  end

  assign prdata                = prdata_reg;
  assign pready                = pready_reg;
  assign pslverr               = pslverr_reg;
  assign primary_input_power   = pri_pwr_reg;
  assign secondary_input_power = sec_pwr_reg;
  assign differential_mode     = diff_reg;
  assign select_secondary      = sel_reg;
endmodule : risc_ref_select
`default_nettype wire

/* File: risc_ref_select_properties.sv */
// port-side checks for the reference select block
`timescale 1ns/1ps
`default_nettype none
module risc_ref_select_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        primary_input_power,
  input wire logic        secondary_input_power,
  input wire logic        differential_mode,
  input wire logic        select_secondary
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ctrl_wr;
    psel && penable && pwrite && pready && paddr == 12'h000;
  endsequence
  AST_RDY_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_BAD_ADDR: assert property (pready && paddr > 12'h008 |-> pslverr)
    else $error("unmapped access without error");
  AST_SEC_PWR: assert property (ctrl_wr ##0 !pwdata[5] |=> secondary_input_power == $past(pwdata[3]))
    else $error("secondary power differs from bit");
  AST_PRI_PWR: assert property (ctrl_wr ##0 !pwdata[5] |=> primary_input_power == $past(pwdata[2]))
    else $error("primary power differs from bit");
  AST_DIFF: assert property (ctrl_wr |=> differential_mode == $past(pwdata[1]))
    else $error("reference mode differs from bit");
  AST_AUTO_PWR: assert property (ctrl_wr ##0 pwdata[5] |=> primary_input_power && secondary_input_power)
    else $error("auto mode left an input unpowered");
  AST_DIFF_PRI: assert property (differential_mode |-> !select_secondary)
    else $error("secondary selected in differential mode");
endmodule : risc_ref_select_properties
bind risc_ref_select risc_ref_select_properties risc_ref_select_properties_inst (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .primary_input_power,
  .secondary_input_power, .differential_mode, .select_secondary);
`default_nettype wire

/* File: tb_risc_ref_select.sv */
// directed bench for the reference select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_risc_ref_select;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        primary_status_good, secondary_status_good, manual_select_secondary;
  logic        primary_input_power, secondary_input_power, differential_mode, select_secondary;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pll_status;
  int          n_mismatch = 0;
  int          checks = 0;
  risc_ref_select risc_ref_select_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .primary_status_good, .secondary_status_good, .manual_select_secondary,
    .pll_status, .prdata, .pready, .pslverr, .primary_input_power, .secondary_input_power,
    .differential_mode, .select_secondary);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  // apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask : settle
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pll_status = 8'h5a;
    primary_status_good = 0; secondary_status_good = 0; manual_select_secondary = 0;
    presetn = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0); `CHK("ctrl", 32'h0, rd)
    `CHK("pwr", 2'b00, {primary_input_power, secondary_input_power})
    apb(1, 12'h000, 32'h8); settle(); `CHK("pwr", 2'b01, {primary_input_power, secondary_input_power})
    apb(1, 12'h000, 32'h4); settle(); `CHK("pwr", 2'b10, {primary_input_power, secondary_input_power})
    manual_select_secondary <= 1'b1;
    apb(1, 12'h000, 32'h2); settle(); `CHK("diff", 2'b10, {differential_mode, select_secondary})
    apb(1, 12'h000, 32'h0); settle(); `CHK("sel", 1'b1, select_secondary)
    apb(0, 12'h008, 0); `CHK("pll", 32'h5a, rd)
    apb(1, 12'h000, 32'h1); apb(0, 12'h008, 0); `CHK("pll", 32'h0, rd)
    apb(0, 12'h00c, 0); `CHK("err", 1'b1, err)
    // manual select low, so only auto mode can pick the secondary from here on
    manual_select_secondary <= 1'b0;
    // single-ended kept whenever auto switchover is used
    primary_status_good <= 1'b1; secondary_status_good <= 1'b1;
    apb(1, 12'h000, 32'h20); settle(); `CHK("pwr", 2'b11, {primary_input_power, secondary_input_power})
    `CHK("sel", 1'b0, select_secondary)
    apb(0, 12'h004, 0); `CHK("status", 32'h1e, rd)
    primary_status_good <= 1'b0; settle(); `CHK("sel", 1'b1, select_secondary)
    primary_status_good <= 1'b1; settle(); `CHK("sel", 1'b0, select_secondary)
    apb(1, 12'h000, 32'h30); primary_status_good <= 1'b0; settle();
    `CHK("sel", 1'b1, select_secondary)
    primary_status_good <= 1'b1; settle(); `CHK("sel", 1'b1, select_secondary)
    // second reset in mid-run brings every setting back to its default
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle(); `CHK("rst", 4'h0, {primary_input_power, secondary_input_power, differential_mode, select_secondary})
    apb(0, 12'h000, 0); `CHK("ctrl", 32'h0, rd)
    tally_and_finish();
  end
endmodule : tb_risc_ref_select
`default_nettype wire
